// File: hdl/ssbmc_burst_if.sv
// Link between the register front end and the burst sequencer
`timescale 1ns/10ps
interface ssbmc_burst_if;
  logic start;
  logic fast;
  logic cl2;
  logic strobe;
  logic last;
  logic busy;
  logic [2:0] word_idx;

  modport ctl (output start, output fast, output cl2,
               input strobe, input last, input busy, input word_idx);
  modport seq (input start, input fast, input cl2,
               output strobe, output last, output busy, output word_idx);
endinterface : ssbmc_burst_if

// File: hdl/ssbmc_burst_seq.sv
// Eight-word SDRAM SIMM burst word timing sequencer
`timescale 1ns/10ps
module ssbmc_burst_seq (
  input wire logic pclk,
  input wire logic presetn,
  ssbmc_burst_if.seq bi
);
  import ssbmc_pkg::*;

  ssbmc_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] widx_q, widx_d;
  logic [3:0] lead;
  logic [3:0] gap;

  always_comb begin
    lead = bi.fast ? LEAD_FAST : LEAD_SLOW;
    if (bi.cl2) begin
      lead = lead - CL2_SAVE;
    end
    // Same gap for reads and writes
    gap = bi.fast ? GAP_FAST : GAP_SLOW;
  end

  assign bi.strobe = (state_q != SSBMC_IDLE) && (cnt_q == '0);
  assign bi.last = bi.strobe && (widx_q == LAST_WORD);
  assign bi.busy = (state_q != SSBMC_IDLE);
  assign bi.word_idx = widx_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    widx_d = widx_q;
    unique case (state_q)
      SSBMC_IDLE: begin
        if (bi.start) begin
          // Start cycle counts as cycle one of the lead-in
          state_d = SSBMC_LEAD;
          cnt_d = lead - CNT_TWO;
          widx_d = '0;
        end
      end
      SSBMC_LEAD: begin
        if (cnt_q == '0) begin
          state_d = SSBMC_BURST;
          cnt_d = gap - CNT_ONE;
          widx_d = widx_q + 3'h1;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      SSBMC_BURST: begin
        if (cnt_q == '0) begin
          cnt_d = gap - CNT_ONE;
          if (widx_q == LAST_WORD) begin
            state_d = SSBMC_IDLE;
            widx_d = '0;
          end else begin
            widx_d = widx_q + 3'h1;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: begin
        state_d = SSBMC_IDLE;
        cnt_d = '0;
        widx_d = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SSBMC_IDLE;
      cnt_q <= '0;
      widx_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      widx_q <= widx_d;
    end
  end
endmodule : ssbmc_burst_seq

// File: hdl/ssbmc_pkg.sv
// Constants and types shared by the SIMM burst and multiplex control block
package ssbmc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [11:0] CTRL_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;

  // Control register field positions
  localparam int unsigned MUX_LO = 4;
  localparam int unsigned MUX_HI = 5;
  localparam int unsigned CL2_BIT = 8;
  localparam int unsigned FAST_BIT = 9;
  localparam int unsigned MUX4_BIT = 12;
  localparam int unsigned MASK_LO = 13;
  localparam int unsigned MASK_HI = 18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_F330;

  // Status register field positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_VALID = 1;
  localparam int unsigned ST_MODE_LO = 4;
  localparam int unsigned ST_MODE_HI = 6;
  localparam int unsigned ST_WIDX_LO = 8;
  localparam int unsigned ST_WIDX_HI = 10;

  // Range decode: mask covers address bits 26:21, base field bits 27:21
  localparam int unsigned RANGE_LO = 21;
  localparam int unsigned RANGE_HI = 27;
  localparam int unsigned MASK_W = 6;
  localparam int unsigned BASE_W = 7;

  // Burst timing in clock cycles, first word counted from the start cycle
  localparam int unsigned WORDS = 8;
  localparam logic [3:0] LEAD_SLOW = 4'hA;
  localparam logic [3:0] LEAD_FAST = 4'h9;
  localparam logic [3:0] CL2_SAVE = 4'h2;
  localparam logic [3:0] GAP_SLOW = 4'h2;
  localparam logic [3:0] GAP_FAST = 4'h1;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_TWO = 4'h2;
  localparam logic [2:0] LAST_WORD = 3'h7;

  // Multiplex field encodings
  localparam logic [1:0] MUX_F0 = 2'h0;
  localparam logic [1:0] MUX_F1 = 2'h1;
  localparam logic [1:0] MUX_F2 = 2'h2;
  localparam logic [1:0] MUX_F3 = 2'h3;

  typedef enum logic [2:0] {
    SSBMC_MODE0 = 3'h0,
    SSBMC_MODE1 = 3'h1,
    SSBMC_MODE2 = 3'h2,
    SSBMC_MODE3 = 3'h3,
    SSBMC_MODE4 = 3'h4,
    SSBMC_MODE5 = 3'h5,
    SSBMC_MODE6 = 3'h6
  } ssbmc_mode_e;

  typedef enum logic [2:0] {
    SSBMC_IDLE = 3'b001,
    SSBMC_LEAD = 3'b010,
    SSBMC_BURST = 3'b100
  } ssbmc_state_e;
endpackage : ssbmc_pkg

// File: hdl/ssbmc_top.sv
// SIMM slot control: APB register, burst timing, mux mode and range decode
`timescale 1ns/10ps
// Contract
// - Slow burst: first word cycle ten, then two
// - Fast burst: first word cycle nine, then one
// - Fast bit shortens write bursts likewise
// - Bit twelve with field 00 gives mode four
// - Bit twelve clear: field alone picks mode
// - Patterns 101, 110, 100 give modes 5, 6, 4
// - With bit twelve clear, field 00..11 selects modes zero to three
// - CAS latency two trims lead-in by two
module ssbmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssbmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [ssbmc_pkg::DATA_W-1:0] pwdata,
  output logic [ssbmc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic burst_start,
  input wire logic burst_write,
  input wire logic [31:0] phys_addr,
  input wire logic [ssbmc_pkg::BASE_W-1:0] range_base,
  output logic range_hit,
  output logic [2:0] address_mux_select,
  output logic mux_select_valid,
  output logic cas_latency_two,
  output logic word_strobe,
  output logic word_last,
  output logic word_is_write,
  output logic [2:0] word_index,
  output logic burst_busy
);
  import ssbmc_pkg::*;

  ssbmc_burst_if bi ();

  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic wr_q, wr_d;
  logic [2:0] mode_q, mode_d;
  logic valid_q, valid_d;
  logic hit_q, hit_d;
  logic setup;
  logic access;
  logic mapped;
  logic [DATA_W-1:0] status;
  logic [1:0] mux_field;
  logic mux_ext;
  logic [MASK_W-1:0] mask;
  logic [BASE_W-1:0] addr_slice;
  logic [BASE_W-1:0] cmp_mask;

  ssbmc_burst_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .bi(bi)
  );

  // Timing settings follow the register live; change only between bursts
  assign bi.start = burst_start;
  assign bi.fast = ctrl_q[FAST_BIT];
  assign bi.cl2 = ctrl_q[CL2_BIT];

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == CTRL_ADDR) || (paddr == STAT_ADDR);

  always_comb begin
    status = '0;
    status[ST_BUSY] = bi.busy;
    status[ST_VALID] = valid_q;
    status[ST_MODE_HI:ST_MODE_LO] = mode_q;
    status[ST_WIDX_HI:ST_WIDX_LO] = bi.word_idx;
  end

  // Read data and error are prepared in setup so access ends at once
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup) begin
      err_d = !mapped;
      rdata_d = '0;
      if (!pwrite && paddr == CTRL_ADDR) begin
        rdata_d = ctrl_q;
      end else if (!pwrite && paddr == STAT_ADDR) begin
        rdata_d = status;
      end
    end
    if (access && pwrite && paddr == CTRL_ADDR) begin
      // Reserved bits stay hardwired to zero
      ctrl_d = pwdata & CTRL_WMASK;
    end
  end

  assign pready = access;
  assign prdata = rdata_q;
  assign pslverr = access && err_q;

  // Multiplex mode decode
  assign mux_field = ctrl_q[MUX_HI:MUX_LO];
  assign mux_ext = ctrl_q[MUX4_BIT];

  always_comb begin
    mode_d = SSBMC_MODE0;
    valid_d = 1'b1;
    if (!mux_ext) begin
      unique case (mux_field)
        MUX_F0: mode_d = SSBMC_MODE0;
        MUX_F1: mode_d = SSBMC_MODE1;
        MUX_F2: mode_d = SSBMC_MODE2;
        MUX_F3: mode_d = SSBMC_MODE3;
      endcase
    end else begin
      unique case (mux_field)
        MUX_F0: mode_d = SSBMC_MODE4;
        MUX_F1: mode_d = SSBMC_MODE5;
        MUX_F2: mode_d = SSBMC_MODE6;
        MUX_F3: begin
          // Undefined pattern: fall back to mode zero, flag it
          mode_d = SSBMC_MODE0;
          valid_d = 1'b0;
        end
      endcase
    end
  end

  // Range compare: masked-off low bits of the window are ignored
  assign mask = ctrl_q[MASK_HI:MASK_LO];
  assign addr_slice = phys_addr[RANGE_HI:RANGE_LO];
  assign cmp_mask = {1'b1, mask};

  always_comb begin
    hit_d = ((addr_slice ^ range_base) & cmp_mask) == '0;
    if (phys_addr[31:RANGE_HI+1] != '0) begin
      hit_d = 1'b0;
    end
  end

  always_comb begin
    wr_d = wr_q;
    if (burst_start && !bi.busy) begin
      wr_d = burst_write;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      rdata_q <= '0;
      err_q <= 1'b0;
      wr_q <= 1'b0;
      mode_q <= SSBMC_MODE0;
      valid_q <= 1'b1;
      hit_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      wr_q <= wr_d;
      mode_q <= mode_d;
      valid_q <= valid_d;
      hit_q <= hit_d;
    end
  end

  assign address_mux_select = mode_q;
  assign mux_select_valid = valid_q;
  assign range_hit = hit_q;
  assign cas_latency_two = ctrl_q[CL2_BIT];
  assign word_strobe = bi.strobe;
  assign word_last = bi.last;
  assign word_is_write = wr_q;
  assign word_index = bi.word_idx;
  assign burst_busy = bi.busy;
endmodule : ssbmc_top

// File: verif/ssbmc_checker.sv
// Port assertions for the SIMM burst and mux block
`timescale 1ns/10ps
module ssbmc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssbmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [ssbmc_pkg::DATA_W-1:0] pwdata,
  input wire logic burst_start,
  input wire logic burst_busy,
  input wire logic [31:0] phys_addr,
  input wire logic [ssbmc_pkg::BASE_W-1:0] range_base,
  input wire logic range_hit,
  input wire logic [2:0] address_mux_select,
  input wire logic mux_select_valid,
  input wire logic cas_latency_two,
  input wire logic word_strobe,
  input wire logic word_last,
  input wire logic [2:0] word_index
);
  import ssbmc_pkg::*;
  logic [31:0] c_q;
  logic wr, f, hx;
  logic [3:0] xm;
  assign wr = psel && penable && pwrite && paddr == CTRL_ADDR;
  assign f = c_q[FAST_BIT];
  assign xm = c_q[12] && c_q[5:4] == 2'h3 ? 4'h0 : {1'b1, c_q[12], c_q[5:4]};
  assign hx = phys_addr[31:27] == {4'h0, range_base[6]} &&
    ((phys_addr[26:21] ^ range_base[5:0]) & c_q[18:13]) == 6'h00;
  // Shadow of the control word, as its fields are not all on pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= CTRL_RESET;
    end else if (wr) begin
      c_q <= pwdata & CTRL_WMASK;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_slow_gap: assert property (
    word_strobe && !word_last && !f |=> !word_strobe ##1 word_strobe)
    else $error("slow word gap");
  a_fast_gap: assert property (
    word_strobe && !word_last && f |=> word_strobe) else $error("fast gap");
  a_lead_slow: assert property (
    burst_start && !burst_busy && !f && !cas_latency_two
    |=> (!word_strobe) [*8] ##1 word_strobe) else $error("slow lead");
  a_lead_fast: assert property (
    burst_start && !burst_busy && f && !cas_latency_two
    |=> (!word_strobe) [*7] ##1 word_strobe) else $error("fast lead");
  a_lead_short: assert property (
    burst_start && !burst_busy && !f && cas_latency_two
    |=> (!word_strobe) [*6] ##1 word_strobe) else $error("short lead");
  a_lead_both: assert property (
    burst_start && !burst_busy && f && cas_latency_two
    |=> (!word_strobe) [*5] ##1 word_strobe) else $error("fast short lead");
  a_cl2_pin: assert property (
    cas_latency_two == c_q[CL2_BIT]) else $error("latency pin");
  a_mode_decode: assert property (
    wr |-> ##2 {mux_select_valid, address_mux_select} == xm)
    else $error("mux mode decode");
  // Reset edge excluded: the registered hit lags the live compare
  a_range_gate: assert property (
    presetn |=> range_hit == $past(hx)) else $error("range compare");
  a_last_word: assert property (
    word_last |-> word_strobe && word_index == 3'h7) else $error("last word");
endmodule : ssbmc_checker
bind ssbmc_top ssbmc_checker i_ssbmc_checker (.*);

// File: verif/ssbmc_simm_model.sv
// Memory-side observer that times the words of each burst
`timescale 1ns/10ps
module ssbmc_simm_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic burst_start,
  input wire logic burst_busy,
  input wire logic word_strobe,
  output logic [7:0] lead,
  output logic [7:0] gap
);
  logic [7:0] cnt;
  logic first;
  // Start cycle counts as one, so cnt is the strobe's cycle number
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      first <= 1'b0;
      lead <= 8'h00;
      gap <= 8'h00;
    end else if (burst_start && !burst_busy) begin
      cnt <= 8'h02;
      first <= 1'b1;
    end else if (word_strobe) begin
      cnt <= 8'h01;
      first <= 1'b0;
      if (first) begin
        lead <= cnt;
      end else begin
        gap <= cnt;
      end
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : ssbmc_simm_model

// File: verif/tb_ssbmc_top.sv
// APB, mux mode, burst timing and range tests for the SIMM block
`timescale 1ns/10ps
module tb_ssbmc_top;
  import ssbmc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, burst_start = 1'b0, burst_write = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, phys_addr = 32'h0000_0000;
  logic [6:0] range_base = 7'h05;
  logic [31:0] prdata, rd;
  logic pready, pslverr, range_hit, mux_select_valid, cas_latency_two;
  logic word_strobe, word_last, word_is_write, burst_busy, err;
  logic [2:0] address_mux_select, word_index;
  logic [7:0] lead, gap;
  logic [32:0] rt [3] = '{33'h1_00C0_0000, 33'h0_04A0_0000, 33'h0_10A0_0000};
  int fail_count = 0;
  int total_checks = 0;
  ssbmc_top i_ssbmc_top (.*);
  ssbmc_simm_model i_ssbmc_simm_model (.*);
  always #5 pclk = ~pclk;
  task automatic check(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic complete_run;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [3:0] xmode(input logic [2:0] s);
    return s[2] && s[1:0] == 2'h3 ? 4'h0 : {1'b1, s};
  endfunction : xmode
  // Bit 8 doubles as the write flag, so reads and writes both get timed
  task automatic burst(input logic [31:0] c);
    logic [3:0] ld, gp;
    int n;
    ld = (c[9] ? LEAD_FAST : LEAD_SLOW) - (c[8] ? CL2_SAVE : 4'h0);
    gp = c[9] ? GAP_FAST : GAP_SLOW;
    n = 0;
    apb(1'b1, CTRL_ADDR, c);
    @(posedge pclk);
    burst_start <= 1'b1;
    burst_write <= c[8];
    @(posedge pclk);
    burst_start <= 1'b0;
    do @(posedge pclk); while (word_last !== 1'b1 && ++n < 40);
    check("last", word_last, 1'b1);
    @(posedge pclk);
    check("lead", lead, ld);
    check("gap", gap, gp);
    check("write", word_is_write, c[8]);
  endtask : burst
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0000_0000);
    check("reset", rd, CTRL_RESET);
    apb(1'b1, CTRL_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, CTRL_ADDR, 32'h0000_0000);
    check("access", rd, CTRL_WMASK);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped", err, 1'b1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, CTRL_ADDR, {19'h0_0000, i[2], 6'h00, i[1:0], 4'h0});
      apb(1'b0, STAT_ADDR, 32'h0000_0000);
      check("mode", {rd[1], rd[6:4]}, xmode(i[2:0]));
    end
    for (int i = 0; i < 4; i++) begin
      burst({22'h00_0000, i[1:0], 8'h00});
    end
    apb(1'b1, CTRL_ADDR, 32'h0006_0000);
    foreach (rt[i]) begin
      phys_addr <= rt[i][31:0];
      repeat (2) @(posedge pclk);
      check("range", range_hit, rt[i][32]);
    end
    // Mid-run reset must return the control word to its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0000_0000);
    check("rereset", rd, CTRL_RESET);
    complete_run();
  end
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule : tb_ssbmc_top
